// >>> common/host_io_pkg.sv
/*
 Shared constants for the host I/O gate array: register offsets, bit positions,
 reset values, interrupt vectors and timing counts.
 Assumes a single 40 MHz core clock.
*/
package host_io_pkg;
    localparam int CORE_CLK_HZ = 40_000_000;
    localparam int EXT_CLK_HZ = 2_457_600;
    localparam int TICK_HZ = 614_400;
    localparam int PRESCALE_DIV = EXT_CLK_HZ / TICK_HZ;
    localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_DIV - 1);
    localparam int SETTLE_US = 1000;
    localparam int SETTLE_CYCLES_DEF = SETTLE_US * (CORE_CLK_HZ / 1_000_000);
    localparam int SETTLE_W = 20;

    localparam logic [3:0] OFS_CAP_LO = 4'h0;
    localparam logic [3:0] OFS_CAP_HI = 4'h1;
    localparam logic [3:0] OFS_LAMP = 4'h2;
    localparam logic [3:0] OFS_IRQ = 4'h4;
    localparam logic [3:0] OFS_SHIFT = 4'h6;
    localparam logic [1:0] SEL_LCD = 2'h2;
    localparam logic [1:0] SEL_SERIAL = 2'h3;

    localparam int BANK_BIT = 0;
    localparam int TRIG_RISE_BIT = 1;
    localparam int TRIG_FALL_BIT = 2;
    localparam int HS_SET_BIT = 0;
    localparam int HS_CLR_BIT = 1;
    localparam int LINE_PWR_BIT = 3;
    localparam int LINE_AUX_BIT = 4;
    localparam int BAUD_BIT = 0;

    localparam int NUM_SRC = 6;
    localparam int SRC_SUBCPU = 0;
    localparam int SRC_SERIAL = 1;
    localparam int SRC_SLAVE = 2;
    localparam int SRC_CAPTURE = 3;
    localparam int SRC_WRAP = 4;
    localparam int SRC_EXPANSION = 5;
    localparam logic [7:0] VEC_TABLE [NUM_SRC] = '{8'hF0, 8'hF2, 8'hF4, 8'hF6, 8'hF8, 8'hFA};
    localparam logic [7:0] NO_VECTOR = 8'hFF;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] LAMP_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
endpackage

// >>> common/shift_link_if.sv
/*
 Carrier between the gate array core and its sub-CPU shift register.
 Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface shift_link_if;
    logic load;
    logic [7:0] load_data;
    logic [7:0] shift_data;
    logic owner_sub;
    modport host (output load, output load_data, input shift_data, input owner_sub);
    modport shifter (input load, input load_data, output shift_data, output owner_sub);
endinterface

// >>> logic/shift_link.sv
/*
 Serial shift register toward the sub-CPU, clocked by the sub-CPU shift clock.
 Assumes shift clock, serial input and owner select arrive asynchronously.
*/
`timescale 1ns/1ps
module shift_link
    import host_io_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic owner_in,
    output logic so_out,
    shift_link_if.shifter lk
);
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic sck_prev_reg;
    logic [7:0] data_reg;
    logic [7:0] data_next;
    logic so_next;
    logic sck_rise;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_reg <= 3'h1; // Shift clock idles high
            sync_reg <= 3'h1;
            sck_prev_reg <= 1'b1;
        end else begin
            meta_reg <= {owner_in, si_in, sck_in};
            sync_reg <= meta_reg;
            sck_prev_reg <= sync_reg[0];
        end
    end

    assign sck_rise = sync_reg[0] & ~sck_prev_reg;
    assign lk.owner_sub = sync_reg[2];
    assign lk.shift_data = data_reg;

    always_comb begin
        data_next = data_reg;
        if (sync_reg[2] && sck_rise) begin
            data_next = {data_reg[6:0], sync_reg[1]};
        end else if (!sync_reg[2] && lk.load) begin
            data_next = lk.load_data;
        end
        so_next = data_next[7];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_reg <= 8'h00;
            so_out <= 1'b0;
        end else begin
            data_reg <= data_next;
            so_out <= so_next;
        end
    end

    property p_shift;
        @(posedge core_clk) disable iff (rst)
        (sync_reg[2] && sck_rise) |=> data_reg == {$past(data_reg[6:0]), $past(sync_reg[1])};
    endproperty
    a_shift: assert property (p_shift) else $error("shift step wrong");

    property p_owner_load;
        @(posedge core_clk) disable iff (rst)
        (sync_reg[2] && !sck_rise) |=> $stable(data_reg);
    endproperty
    a_owner_load: assert property (p_owner_load) else $error("host changed owned register");
endmodule

// >>> logic/host_io_gate_array.sv
/*
 Main-CPU peripheral gate array: I/O decode, six-source vectored interrupt
 controller, free-running counter with capture, sub-CPU handshake and ports.
 Assumes all pins are asynchronous to core_clk and the CPU strobes last many
 core clock cycles.
*/
`timescale 1ns/1ps
//Contract
// - Six sources, fixed priority, sub-CPU highest
// - Vectors F0, F2, F4, FA for pin sources
// - Vectors F8 wrap, F6 capture
// - One enable bit per source number
// - Status bit per source, shares mask address
// - Acknowledge drives serviced source vector
// - Acknowledge needs opcode fetch and request
// - Dedicated interrupt output toward CPU
// - Divide external clock to counter tick
// - 16-bit counter, bit 0 gives baud
// - Read 00 captures, returns low byte
// - Control bits 1,2 with barcode trigger capture
// - Handshake flag grants host, else interrupts sub-CPU
// - Shift register clocked by sub-CPU shift clock
// - Owner select high gives sub-CPU ownership
// - Bit 0 of 00 drives bank select
// - Bits 0-2 of 02 drive lamps
// - Bits 3,4 line power, inhibit while settling
// - Four address lines, two chip selects
// - Strobes count only with I/O request
// - Bank select low means bank 0
module host_io_gate_array
    import host_io_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] db_in,
    output logic [7:0] db_out,
    output logic db_oe,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic io_request_strobe_n,
    input wire logic opcode_fetch_cycle_n,
    input wire logic ext_clk_in,
    input wire logic barcode_in,
    input wire logic subcpu_irq_in_n,
    input wire logic serial_ctrl_irq_in_n,
    input wire logic slave_cpu_irq_in_n,
    input wire logic expansion_irq_in_n,
    output logic host_irq_n,
    output logic serial_ctrl_select_n,
    output logic lcd_ctrl_select_n,
    output logic tx_clk_out,
    output logic rx_clk_out,
    output logic bank_select_out,
    output logic shift_lamp_center,
    output logic shift_lamp_upper,
    output logic shift_lamp_lower,
    output logic line_power_out,
    output logic line_aux_out,
    output logic line_driver_inhibit,
    output logic subcpu_irq_out,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic shift_owner_select,
    output logic so_out
);
    logic [21:0] meta_reg;
    logic [21:0] sync_reg;
    logic rd_prev_reg, wr_prev_reg, ack_prev_reg, ext_prev_reg, bar_prev_reg;
    logic rd_s, wr_s, iorq_s, fetch_s, ext_s, bar_s;
    logic [3:0] irq_s, addr_s;
    logic [7:0] db_s;
    logic rd_act, wr_act, ack_act, rd_start, wr_start, ack_start;

    logic [7:0] ctrl_reg, ctrl_next, lamp_reg, lamp_next, mask_reg, mask_next, db_out_next;
    logic [NUM_SRC-1:0] status_reg, status_next;
    logic ready_reg, ready_next, sub_irq_next, db_oe_next, inhibit_next;
    logic [1:0] prescale_reg, prescale_next;
    logic [15:0] counter_reg, counter_next, capture_reg, capture_next;
    logic [SETTLE_W-1:0] settle_reg, settle_next;
    logic host_irq_next, serial_cs_next, lcd_cs_next, baud_next;
    logic tick, wrap, trig, any_pend, reg_hit;
    logic [NUM_SRC-1:0] ev, pend, clr;
    logic [2:0] sel;
    logic load;

    shift_link_if lk ();
    shift_link u_shift (.core_clk(core_clk), .rst(rst), .sck_in(sck_in), .si_in(si_in),
        .owner_in(shift_owner_select), .so_out(so_out), .lk(lk));

    // Pin synchronisers and strobe history
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_reg <= 22'h3FFFFF;
            sync_reg <= 22'h3FFFFF;
            rd_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
            ack_prev_reg <= 1'b0;
            ext_prev_reg <= 1'b1; // Match synchroniser reset level
            bar_prev_reg <= 1'b1;
        end else begin
            meta_reg <= {db_in, addr_in, expansion_irq_in_n, slave_cpu_irq_in_n, serial_ctrl_irq_in_n,
                subcpu_irq_in_n, barcode_in, ext_clk_in, opcode_fetch_cycle_n, io_request_strobe_n, wr_n, rd_n};
            sync_reg <= meta_reg;
            rd_prev_reg <= rd_act;
            wr_prev_reg <= wr_act;
            ack_prev_reg <= ack_act;
            ext_prev_reg <= ext_s;
            bar_prev_reg <= bar_s;
        end
    end

    assign rd_s = sync_reg[0];
    assign wr_s = sync_reg[1];
    assign iorq_s = sync_reg[2];
    assign fetch_s = sync_reg[3];
    assign ext_s = sync_reg[4];
    assign bar_s = sync_reg[5];
    assign irq_s = sync_reg[9:6];
    assign addr_s = sync_reg[13:10];
    assign db_s = sync_reg[21:14];

    assign rd_act = ~rd_s & ~iorq_s & fetch_s;
    assign wr_act = ~wr_s & ~iorq_s;
    assign ack_act = ~fetch_s & ~iorq_s;
    assign rd_start = rd_act & ~rd_prev_reg;
    assign wr_start = wr_act & ~wr_prev_reg;
    assign ack_start = ack_act & ~ack_prev_reg;
    assign lk.load = load;
    assign lk.load_data = db_s;

    always_comb begin
        ctrl_next = ctrl_reg;
        lamp_next = lamp_reg;
        mask_next = mask_reg;
        ready_next = ready_reg;
        capture_next = capture_reg;
        db_out_next = db_out;
        prescale_next = prescale_reg;
        counter_next = counter_reg;
        load = 1'b0;
        tick = 1'b0;
        clr = '0;
        sel = 3'd0;
        any_pend = 1'b0;
        // Prescaler on external clock edges
        if (ext_s && !ext_prev_reg) begin
            if (prescale_reg == PRESCALE_LAST) begin
                prescale_next = 2'h0;
                tick = 1'b1;
                counter_next = counter_reg + 16'h0001;
            end else begin
                prescale_next = prescale_reg + 2'h1;
            end
        end
        wrap = tick && (counter_reg == COUNT_MAX);
        trig = (ctrl_reg[TRIG_RISE_BIT] & bar_s & ~bar_prev_reg)
            | (ctrl_reg[TRIG_FALL_BIT] & ~bar_s & bar_prev_reg);
        if (trig) begin
            capture_next = counter_reg;
        end
        // Source events, pin requests active low
        ev = '0;
        ev[SRC_SUBCPU] = ~irq_s[0];
        ev[SRC_SERIAL] = ~irq_s[1];
        ev[SRC_SLAVE] = ~irq_s[2];
        ev[SRC_EXPANSION] = ~irq_s[3];
        ev[SRC_CAPTURE] = trig;
        ev[SRC_WRAP] = wrap;
        pend = status_reg & mask_reg[NUM_SRC-1:0];
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                sel = 3'(i);
                any_pend = 1'b1;
            end
        end
        if (ack_start) begin
            db_out_next = any_pend ? VEC_TABLE[sel] : NO_VECTOR;
            if (any_pend) begin
                clr[sel] = 1'b1;
            end
        end
        reg_hit = (addr_s == OFS_CAP_LO) || (addr_s == OFS_CAP_HI) || (addr_s == OFS_LAMP)
            || (addr_s == OFS_IRQ) || (addr_s == OFS_SHIFT);
        if (rd_start) begin
            unique case (addr_s)
                OFS_CAP_LO: begin
                    capture_next = counter_reg;
                    db_out_next = counter_reg[7:0];
                end
                OFS_CAP_HI: db_out_next = capture_reg[15:8];
                OFS_LAMP: db_out_next = lamp_reg;
                OFS_IRQ: db_out_next = {ready_reg, 1'b0, status_reg};
                OFS_SHIFT: db_out_next = lk.shift_data;
                default: db_out_next = 8'h00;
            endcase
        end
        if (wr_start) begin
            unique case (addr_s)
                OFS_CAP_LO: ctrl_next = db_s;
                OFS_CAP_HI: begin
                    if (db_s[HS_CLR_BIT]) begin
                        ready_next = 1'b0;
                    end else if (db_s[HS_SET_BIT]) begin
                        ready_next = 1'b1;
                    end
                end
                OFS_LAMP: lamp_next = db_s;
                OFS_IRQ: mask_next = db_s;
                OFS_SHIFT: load = ready_reg & ~lk.owner_sub;
                default: ;
            endcase
        end
        status_next = (status_reg & ~clr) | ev;
        host_irq_next = ~|pend;
        sub_irq_next = ~ready_next;
        db_oe_next = (rd_act & reg_hit) | ack_act;
        serial_cs_next = ~((rd_act | wr_act) && addr_s[3:2] == SEL_SERIAL);
        lcd_cs_next = ~((rd_act | wr_act) && addr_s[3:2] == SEL_LCD);
        baud_next = counter_reg[BAUD_BIT];
        if (!lamp_reg[LINE_PWR_BIT]) begin
            settle_next = '0;
        end else if (settle_reg < SETTLE_W'(SETTLE_CYCLES)) begin
            settle_next = settle_reg + SETTLE_W'(1);
        end else begin
            settle_next = settle_reg;
        end
        inhibit_next = (settle_next < SETTLE_W'(SETTLE_CYCLES));
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
            lamp_reg <= LAMP_RST;
            mask_reg <= MASK_RST;
            status_reg <= '0;
            ready_reg <= 1'b0;
            subcpu_irq_out <= 1'b1;
            prescale_reg <= 2'd0;
            counter_reg <= COUNT_RST;
            capture_reg <= COUNT_RST;
            db_out <= 8'h00;
            db_oe <= 1'b0;
            settle_reg <= '0;
            line_driver_inhibit <= 1'b1;
            host_irq_n <= 1'b1;
            serial_ctrl_select_n <= 1'b1;
            lcd_ctrl_select_n <= 1'b1;
            tx_clk_out <= 1'b0;
            rx_clk_out <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            lamp_reg <= lamp_next;
            mask_reg <= mask_next;
            status_reg <= status_next;
            ready_reg <= ready_next;
            subcpu_irq_out <= sub_irq_next;
            prescale_reg <= prescale_next;
            counter_reg <= counter_next;
            capture_reg <= capture_next;
            db_out <= db_out_next;
            db_oe <= db_oe_next;
            settle_reg <= settle_next;
            line_driver_inhibit <= inhibit_next;
            host_irq_n <= host_irq_next;
            serial_ctrl_select_n <= serial_cs_next;
            lcd_ctrl_select_n <= lcd_cs_next;
            tx_clk_out <= baud_next;
            rx_clk_out <= baud_next;
        end
    end

    assign bank_select_out = ctrl_reg[BANK_BIT];
    assign shift_lamp_center = lamp_reg[0];
    assign shift_lamp_upper = lamp_reg[1];
    assign shift_lamp_lower = lamp_reg[2];
    assign line_power_out = lamp_reg[LINE_PWR_BIT];
    assign line_aux_out = lamp_reg[LINE_AUX_BIT];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_top_prio;
        (ack_start && pend[SRC_SUBCPU]) |=> db_out == 8'hF0 && db_oe;
    endproperty
    a_top_prio: assert property (p_top_prio) else $error("highest source not served");
    property p_pin_vec;
        (ack_start && pend == 6'h20) |=> db_out == 8'hFA;
    endproperty
    a_pin_vec: assert property (p_pin_vec) else $error("expansion vector wrong");
    property p_wrap_vec;
        (ack_start && pend inside {6'h08, 6'h10}) |=> db_out == ($past(pend[SRC_WRAP]) ? 8'hF8 : 8'hF6)
            && ((status_reg & $past(pend) & ~$past(ev)) == 6'h00);
    endproperty
    a_wrap_vec: assert property (p_wrap_vec) else $error("internal source vector wrong");
    property p_irq_out;
        (|(status_reg & mask_reg[NUM_SRC-1:0])) |=> !host_irq_n;
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("interrupt output missing");
    property p_status_set;
        !irq_s[1] |=> status_reg[SRC_SERIAL];
    endproperty
    a_status_set: assert property (p_status_set) else $error("status not set");
    property p_no_drive;
        !(rd_act || ack_act) |=> !db_oe;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("bus driven outside cycle");
    property p_capture;
        (rd_start && addr_s == OFS_CAP_LO) |=> capture_reg == $past(counter_reg) && db_out == capture_reg[7:0];
    endproperty
    a_capture: assert property (p_capture) else $error("capture read wrong");
    property p_bank;
        (wr_start && addr_s == OFS_CAP_LO) |=> bank_select_out == $past(db_s[BANK_BIT]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank select not updated");
    property p_count;
        !tick |=> $stable(counter_reg);
    endproperty
    a_count: assert property (p_count) else $error("counter moved without tick");
    property p_handshake;
        (wr_start && addr_s == OFS_CAP_HI && db_s[HS_CLR_BIT]) |=> !ready_reg && subcpu_irq_out;
    endproperty
    a_handshake: assert property (p_handshake) else $error("handshake clear failed");
    property p_inhibit;
        $rose(line_power_out) |-> line_driver_inhibit [*8];
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("driver not inhibited");
endmodule

// >>> test/sub_cpu_model.sv
/*
 Sub-CPU end of the shift link: owner select, shift clock and serial data.
 Assumes the gate array samples these pins asynchronously to core_clk.
*/
`timescale 1ns/1ps
module sub_cpu_model (
    input wire logic core_clk,
    input wire logic so_in,
    output logic sck_out,
    output logic si_out,
    output logic owner_out
);
    initial begin
        sck_out = 1'h1;
        si_out = 1'h0;
        owner_out = 1'h0;
    end

    // Eight bits MSB first, shift clock idle high between frames
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        int i;
        @(posedge core_clk) owner_out <= 1'h1;
        repeat (6) @(posedge core_clk);
        for (i = 7; i >= 0; i--) begin
            sck_out <= 1'h0;
            si_out <= tx[i];
            repeat (8) @(posedge core_clk);
            @(negedge core_clk) rx[i] = so_in;
            @(posedge core_clk) sck_out <= 1'h1;
            repeat (8) @(posedge core_clk);
        end
        si_out <= ~tx[0];
        owner_out <= 1'h0;
    endtask
endmodule

// >>> test/host_io_gate_array_tb.sv
/*
 Self-checking bench for the host I/O gate array: CPU I/O cycles, acks.
 Assumes the package constants and a sub-CPU model on the shift link.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module host_io_gate_array_tb;
    import host_io_pkg::*;
    localparam int SETTLE = 20;
    localparam logic [3:0] RD = 4'h5;
    localparam logic [3:0] WR = 4'h9;
    localparam logic [3:0] ACK = 4'hC;
    localparam logic [3:0] FETCH = 4'hE;
    localparam logic [3:0] NOIO = 4'h7;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] db_in = 8'h00;
    logic rd_n = 1'h1, wr_n = 1'h1, io_request_strobe_n = 1'h1, opcode_fetch_cycle_n = 1'h1;
    logic ext_clk_in = 1'h0, barcode_in = 1'h0;
    logic subcpu_irq_in_n = 1'h1, serial_ctrl_irq_in_n = 1'h1, slave_cpu_irq_in_n = 1'h1;
    logic expansion_irq_in_n = 1'h1;
    logic [7:0] db_out;
    logic db_oe, host_irq_n, serial_ctrl_select_n, lcd_ctrl_select_n, tx_clk_out, rx_clk_out;
    logic bank_select_out, shift_lamp_center, shift_lamp_upper, shift_lamp_lower;
    logic line_power_out, line_aux_out, line_driver_inhibit, subcpu_irq_out;
    logic sck_in, si_in, shift_owner_select, so_out;
    int error_cnt = 0;
    int comparisons = 0;
    int i;
    logic [7:0] got, rx;
    logic oe, ser_n, lcd_n;
    logic [15:0] cnt;
    logic [7:0] vec [5] = '{8'hF0, 8'hF2, 8'hF4, 8'hFA, 8'hFF};

    host_io_gate_array #(.SETTLE_CYCLES(SETTLE)) i_host_io_gate_array (.core_clk, .rst, .addr_in,
        .db_in, .db_out, .db_oe, .rd_n, .wr_n, .io_request_strobe_n, .opcode_fetch_cycle_n,
        .ext_clk_in, .barcode_in, .subcpu_irq_in_n, .serial_ctrl_irq_in_n, .slave_cpu_irq_in_n,
        .expansion_irq_in_n, .host_irq_n, .serial_ctrl_select_n, .lcd_ctrl_select_n, .tx_clk_out,
        .rx_clk_out, .bank_select_out, .shift_lamp_center, .shift_lamp_upper, .shift_lamp_lower,
        .line_power_out, .line_aux_out, .line_driver_inhibit, .subcpu_irq_out, .sck_in, .si_in,
        .shift_owner_select, .so_out);

    sub_cpu_model i_sub_cpu_model (.core_clk(core_clk), .so_in(so_out), .sck_out(sck_in),
        .si_out(si_in), .owner_out(shift_owner_select));

    always #12.5 core_clk = ~core_clk;

    task finish_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One I/O cycle; ctl is {rd_n, wr_n, iorq_n, m1_n}
    task bus(input logic [3:0] ctl, input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        {rd_n, wr_n, io_request_strobe_n, opcode_fetch_cycle_n} <= ctl;
        addr_in <= a;
        db_in <= d;
        repeat (5) @(posedge core_clk);
        #1;
        got = db_out;
        oe = db_oe;
        ser_n = serial_ctrl_select_n;
        lcd_n = lcd_ctrl_select_n;
        @(posedge core_clk);
        {rd_n, wr_n, io_request_strobe_n, opcode_fetch_cycle_n} <= 4'hF;
        addr_in <= ~a;
        db_in <= ~d;
        repeat (6) @(posedge core_clk);
    endtask

    task rd16;
        bus(RD, OFS_CAP_LO, 8'h00);
        cnt[7:0] = got;
        bus(RD, OFS_CAP_HI, 8'h00);
        cnt[15:8] = got;
    endtask

    task ext(input int n);
        repeat (n) begin
            @(posedge core_clk) ext_clk_in <= 1'h1;
            repeat (8) @(posedge core_clk);
            ext_clk_in <= 1'h0;
            repeat (8) @(posedge core_clk);
        end
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        finish_test;
    end

    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'h0;
        repeat (4) @(posedge core_clk);
        `CHK({bank_select_out, line_driver_inhibit, host_irq_n, subcpu_irq_out}, 4'h7)
        bus(RD, OFS_IRQ, 8'h00); `CHK(got, 8'h00)
        // Ports and decode
        bus(WR, OFS_CAP_LO, 8'h01); `CHK(bank_select_out, 1'h1)
        bus(WR, OFS_CAP_LO, 8'h00); `CHK(bank_select_out, 1'h0)
        bus(WR, OFS_LAMP, 8'h1F);
        `CHK({line_aux_out, line_power_out, line_driver_inhibit}, 3'h7)
        `CHK({shift_lamp_lower, shift_lamp_upper, shift_lamp_center}, 3'h7)
        repeat (SETTLE) @(posedge core_clk);
        `CHK(line_driver_inhibit, 1'h0)
        bus(WR, OFS_LAMP, 8'h05);
        `CHK({line_power_out, line_driver_inhibit}, 2'h1)
        `CHK({shift_lamp_lower, shift_lamp_upper, shift_lamp_center}, 3'h5)
        bus(RD, OFS_LAMP, 8'h00); `CHK(got, 8'h05)
        bus(RD, 4'h3, 8'h00); `CHK(oe, 1'h0)
        bus(NOIO, OFS_LAMP, 8'h00); `CHK(oe, 1'h0)
        bus(RD, 4'hC, 8'h00); `CHK({ser_n, lcd_n}, 2'h1)
        bus(RD, 4'h8, 8'h00); `CHK({ser_n, lcd_n}, 2'h2)
        `CHK({serial_ctrl_select_n, lcd_ctrl_select_n}, 2'h3)
        // Counter and capture by read
        rd16; `CHK({cnt, tx_clk_out}, 17'h00000)
        ext(8); rd16; `CHK(cnt, 16'h0002)
        ext(4); rd16; `CHK({cnt, tx_clk_out, rx_clk_out}, {16'h0003, 2'h3})
        // Pin sources, priority and vectors
        @(posedge core_clk);
        {subcpu_irq_in_n, serial_ctrl_irq_in_n, slave_cpu_irq_in_n, expansion_irq_in_n} <= 4'h0;
        bus(RD, OFS_IRQ, 8'h00); `CHK({got, host_irq_n}, {8'h27, 1'h1})
        bus(WR, OFS_IRQ, 8'h3F); `CHK(host_irq_n, 1'h0)
        {subcpu_irq_in_n, serial_ctrl_irq_in_n, slave_cpu_irq_in_n, expansion_irq_in_n} <= 4'hF;
        bus(FETCH, 4'h0, 8'h00); `CHK(oe, 1'h0)
        for (i = 0; i < 5; i++) begin
            bus(ACK, 4'h0, 8'h00); `CHK({oe, got}, {1'h1, vec[i]})
        end
        `CHK(host_irq_n, 1'h1)
        // Barcode capture events
        bus(WR, OFS_IRQ, 8'h00);
        bus(WR, OFS_CAP_LO, 8'h02);
        @(posedge core_clk) barcode_in <= 1'h1;
        bus(RD, OFS_IRQ, 8'h00); `CHK(got, 8'h08)
        bus(ACK, 4'h0, 8'h00); `CHK(got, 8'hFF)
        bus(WR, OFS_IRQ, 8'h08);
        bus(ACK, 4'h0, 8'h00); `CHK(got, 8'hF6)
        bus(WR, OFS_CAP_LO, 8'h04);
        @(posedge core_clk) barcode_in <= 1'h0;
        bus(ACK, 4'h0, 8'h00); `CHK(got, 8'hF6)
        // Handshake and shift link
        bus(WR, OFS_CAP_HI, 8'h01); `CHK(subcpu_irq_out, 1'h0)
        bus(WR, OFS_SHIFT, 8'hA5);
        bus(RD, OFS_IRQ, 8'h00); `CHK(got, 8'h80)
        bus(RD, OFS_SHIFT, 8'h00); `CHK(got, 8'hA5)
        bus(WR, OFS_CAP_HI, 8'h03); `CHK(subcpu_irq_out, 1'h1)
        bus(WR, OFS_SHIFT, 8'h3C);
        i_sub_cpu_model.xfer(8'h5A, rx); `CHK(rx, 8'hA5)
        bus(WR, OFS_CAP_HI, 8'h01);
        bus(RD, OFS_SHIFT, 8'h00); `CHK(got, 8'h5A)
        finish_test;
    end
endmodule
